//--- dlh_cfg.svh
// Register map, field positions and reset values of the data-link interrupt status block.
`ifndef DLH_CFG_SVH
`define DLH_CFG_SVH
`define DLH_IDX_LINK2_IRQ_ENABLE   12'hB17
`define DLH_IDX_LAPD2_OVR_STATUS   12'hB18
`define DLH_IDX_LAPD2_OVR_ENABLE   12'hB19
`define DLH_IDX_LINK3_STATUS       12'hB26
`define DLH_IDX_LINK3_ENABLE       12'hB27
`define DLH_BIT_CHECKSUM           2
`define DLH_BIT_ABORT              1
`define DLH_BIT_IDLE               0
`define DLH_BIT_OVERSIZE           0
`define DLH_BIT_KIND               7
`define DLH_BIT_TX_BEGIN           6
`define DLH_BIT_RX_BEGIN           5
`define DLH_BIT_TX_DONE            4
`define DLH_LINK2_EN_MASK          8'h07
`define DLH_OVR_EN_MASK            8'h01
`define DLH_LINK3_EN_MASK          8'h70
`define DLH_RESET_BYTE             8'h00
`define DLH_RESP_OKAY              2'h0
`define DLH_RESP_SLVERR            2'h2
`define DLH_OVERSIZE_BYTES         276
`endif

//--- dlh_pkg.sv
// Types shared by the data-link interrupt status block.
`default_nettype none
package dlh_pkg;
	typedef logic [7:0]  dlh_byte_t;
	typedef logic [31:0] dlh_word_t;
	typedef logic [13:0] dlh_addr_t;
	typedef enum logic [1:0] {
		DLH_RD_IDLE = 2'h0,
		DLH_RD_RESP = 2'h1
	} dlh_rd_state_t;
endpackage : dlh_pkg
`default_nettype wire

//--- dlh_flag_if.sv
// Interface carrying one sticky flag's event, read strobe and state.
`timescale 1ns/10ps
`default_nettype none
interface dlh_flag_if;
	logic event_pulse;
	logic read_clear;
	logic flag;
	modport keeper (input event_pulse, input read_clear, output flag);
	modport user   (output event_pulse, output read_clear, input flag);
endinterface : dlh_flag_if
`default_nettype wire

//--- dlh_sticky_flag.sv
// One clear-on-read sticky event flag.
`timescale 1ns/10ps
`default_nettype none
module dlh_sticky_flag (
	// Clock and reset.
	input wire logic   core_clk,
	input wire logic   rst_n,
	// Flag connection.
	dlh_flag_if.keeper fl
);
	logic flag_reg;
	logic flag_next;

	assign flag_next = fl.event_pulse | (flag_reg & ~fl.read_clear);
	assign fl.flag   = flag_reg;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end
endmodule : dlh_sticky_flag
`default_nettype wire

//--- dlh_link_irq.sv
// Data-link interrupt enables for link controllers 2 and 3, clear-on-read status for controller 3 and the controller 2 oversize flag.
// Behaviour
// - Checksum-error interrupt of receive controller 2 only while enable bit 2 set.
// - Abort-sequence (seven ones) interrupt of receive controller 2 only while bit 1 set.
// - Idle flag octet interrupt of receive controller 2 only while bit 0 set.
// - Oversize flag sets on message above 276 bytes, clears when read.
// - Oversize interrupt raised only while its enable bit is one.
// - Status bit 7 reads message kind, bit-oriented 0, message-oriented 1, read only.
// - Transmit-begin flag bit 6 sets when transmit controller 3 starts a message.
// - Controller 3 event flags report events since last read, cleared by reading.
// - Receive-begin flag bit 5 sets when receive controller 3 starts a message.
// - Transmit-done flag bit 4 sets when transmit controller 3 finishes a message.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "dlh_cfg.svh"
module dlh_link_irq #(
	// Register bus address width in bits.
	parameter int unsigned ADDR_W = 14
) (
	// Clock and reset.
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	// AXI4-Lite write channels.
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	// AXI4-Lite read channels.
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output dlh_pkg::dlh_word_t    s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	// Controller 2 receive event pulses.
	input  wire logic             rx2_checksum_error,
	input  wire logic             rx2_abort_seq,
	input  wire logic             rx2_idle_flag,
	input  wire logic             lapd2_oversize_event,
	// Controller 3 events and message kind.
	input  wire logic             tx3_begin,
	input  wire logic             rx3_begin,
	input  wire logic             tx3_done,
	input  wire logic             rx3_message_kind,
	// Interrupt request.
	output logic                  irq
);
	import dlh_pkg::*;

	// ********************
	// Elaboration checks
	// ********************
	// The register decode slices a fixed fourteen-bit byte address.
	if (ADDR_W != 14) begin : g_bad_addr_w
		$error("Address width must be fourteen bits.");
	end

	// ********************
	// Register state
	// ********************
	dlh_byte_t     link2_irq_enable_reg;
	dlh_byte_t     lapd2_oversize_enable_reg;
	dlh_byte_t     link3_irq_enable_reg;
	logic          message_kind_reg;
	dlh_byte_t     rd_byte_reg;
	logic          rd_hit_reg;
	logic          aw_held_reg;
	logic          w_held_reg;
	dlh_addr_t     aw_addr_reg;
	dlh_byte_t     w_byte_reg;
	logic          w_lane0_reg;
	logic          bvalid_reg;
	logic          bhit_reg;
	dlh_rd_state_t rd_state_reg;

	// ********************
	// Sticky flags
	// ********************
	dlh_flag_if fl_checksum ();
	dlh_flag_if fl_abort ();
	dlh_flag_if fl_idle ();
	dlh_flag_if fl_oversize ();
	dlh_flag_if fl_tx_begin ();
	dlh_flag_if fl_rx_begin ();
	dlh_flag_if fl_tx_done ();

	dlh_sticky_flag u_checksum (.core_clk(core_clk), .rst_n(rst_n), .fl(fl_checksum));
	dlh_sticky_flag u_abort    (.core_clk(core_clk), .rst_n(rst_n), .fl(fl_abort));
	dlh_sticky_flag u_idle     (.core_clk(core_clk), .rst_n(rst_n), .fl(fl_idle));
	dlh_sticky_flag u_oversize (.core_clk(core_clk), .rst_n(rst_n), .fl(fl_oversize));
	dlh_sticky_flag u_tx_begin (.core_clk(core_clk), .rst_n(rst_n), .fl(fl_tx_begin));
	dlh_sticky_flag u_rx_begin (.core_clk(core_clk), .rst_n(rst_n), .fl(fl_rx_begin));
	dlh_sticky_flag u_tx_done  (.core_clk(core_clk), .rst_n(rst_n), .fl(fl_tx_done));

	// ********************
	// Read decode
	// ********************
	logic      ar_take;
	logic [11:0] ar_idx;
	logic      rd_sel_link2_en;
	logic      rd_sel_ovr_status;
	logic      rd_sel_ovr_en;
	logic      rd_sel_link3_status;
	logic      rd_sel_link3_en;
	logic      rd_hit;
	dlh_byte_t link3_status_byte;
	dlh_byte_t ovr_status_byte;
	dlh_byte_t rd_byte;
	logic      clr_link2;
	logic      clr_ovr;
	logic      clr_link3;

	assign ar_take             = s_axi_arvalid & (rd_state_reg == DLH_RD_IDLE);
	assign ar_idx              = s_axi_araddr[13:2];
	assign rd_sel_link2_en     = (ar_idx == `DLH_IDX_LINK2_IRQ_ENABLE);
	assign rd_sel_ovr_status   = (ar_idx == `DLH_IDX_LAPD2_OVR_STATUS);
	assign rd_sel_ovr_en       = (ar_idx == `DLH_IDX_LAPD2_OVR_ENABLE);
	assign rd_sel_link3_status = (ar_idx == `DLH_IDX_LINK3_STATUS);
	assign rd_sel_link3_en     = (ar_idx == `DLH_IDX_LINK3_ENABLE);
	assign rd_hit = rd_sel_link2_en | rd_sel_ovr_status | rd_sel_ovr_en | rd_sel_link3_status | rd_sel_link3_en;

	assign link3_status_byte = {message_kind_reg, fl_tx_begin.flag, fl_rx_begin.flag, fl_tx_done.flag, 4'h0};
	assign ovr_status_byte   = {7'h00, fl_oversize.flag};

	assign rd_byte = rd_sel_link2_en     ? link2_irq_enable_reg :
	                 rd_sel_ovr_status   ? ovr_status_byte :
	                 rd_sel_ovr_en       ? lapd2_oversize_enable_reg :
	                 rd_sel_link3_status ? link3_status_byte :
	                 rd_sel_link3_en     ? link3_irq_enable_reg : `DLH_RESET_BYTE;

	assign clr_ovr   = ar_take & rd_sel_ovr_status;
	assign clr_link3 = ar_take & rd_sel_link3_status;
	assign clr_link2 = 1'b0;

	assign fl_checksum.event_pulse = rx2_checksum_error;
	assign fl_checksum.read_clear  = clr_link2;
	assign fl_abort.event_pulse    = rx2_abort_seq;
	assign fl_abort.read_clear     = clr_link2;
	assign fl_idle.event_pulse     = rx2_idle_flag;
	assign fl_idle.read_clear      = clr_link2;
	assign fl_oversize.event_pulse = lapd2_oversize_event;
	assign fl_oversize.read_clear  = clr_ovr;
	assign fl_tx_begin.event_pulse = tx3_begin;
	assign fl_tx_begin.read_clear  = clr_link3;
	assign fl_rx_begin.event_pulse = rx3_begin;
	assign fl_rx_begin.read_clear  = clr_link3;
	assign fl_tx_done.event_pulse  = tx3_done;
	assign fl_tx_done.read_clear   = clr_link3;

	// ********************
	// Read channel
	// ********************
	assign s_axi_arready = (rd_state_reg == DLH_RD_IDLE);
	assign s_axi_rvalid  = (rd_state_reg == DLH_RD_RESP);
	assign s_axi_rdata   = {24'h000000, rd_byte_reg};
	assign s_axi_rresp   = rd_hit_reg ? `DLH_RESP_OKAY : `DLH_RESP_SLVERR;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_state_reg <= DLH_RD_IDLE;
			rd_byte_reg  <= `DLH_RESET_BYTE;
			rd_hit_reg   <= 1'b0;
		end else begin
			case (rd_state_reg)
				DLH_RD_IDLE: begin
					if (ar_take) begin
						rd_state_reg <= DLH_RD_RESP;
						rd_byte_reg  <= rd_byte;
						rd_hit_reg   <= rd_hit;
					end
				end
				DLH_RD_RESP: begin
					if (s_axi_rready) begin
						rd_state_reg <= DLH_RD_IDLE;
					end
				end
				default: begin
					rd_state_reg <= DLH_RD_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			message_kind_reg <= 1'b0;
		end else begin
			message_kind_reg <= rx3_message_kind;
		end
	end

	// ********************
	// Write channel
	// ********************
	logic        aw_take;
	logic        w_take;
	logic        wr_fire;
	logic [11:0] aw_idx;
	logic        wr_link2_en;
	logic        wr_ovr_en;
	logic        wr_link3_en;
	logic        wr_hit;

	assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
	assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
	assign aw_take       = s_axi_awvalid & s_axi_awready;
	assign w_take        = s_axi_wvalid & s_axi_wready;
	assign wr_fire       = aw_held_reg & w_held_reg;
	assign aw_idx        = aw_addr_reg[13:2];
	assign wr_link2_en   = wr_fire & w_lane0_reg & (aw_idx == `DLH_IDX_LINK2_IRQ_ENABLE);
	assign wr_ovr_en     = wr_fire & w_lane0_reg & (aw_idx == `DLH_IDX_LAPD2_OVR_ENABLE);
	assign wr_link3_en   = wr_fire & w_lane0_reg & (aw_idx == `DLH_IDX_LINK3_ENABLE);
	assign wr_hit        = (aw_idx == `DLH_IDX_LINK2_IRQ_ENABLE) | (aw_idx == `DLH_IDX_LAPD2_OVR_ENABLE) |
	                       (aw_idx == `DLH_IDX_LINK3_ENABLE) | (aw_idx == `DLH_IDX_LAPD2_OVR_STATUS) |
	                       (aw_idx == `DLH_IDX_LINK3_STATUS);
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bhit_reg ? `DLH_RESP_OKAY : `DLH_RESP_SLVERR;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 14'h0000;
		end else if (aw_take) begin
			aw_held_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			w_held_reg  <= 1'b0;
			w_byte_reg  <= `DLH_RESET_BYTE;
			w_lane0_reg <= 1'b0;
		end else if (w_take) begin
			w_held_reg  <= 1'b1;
			w_byte_reg  <= s_axi_wdata[7:0];
			w_lane0_reg <= s_axi_wstrb[0];
		end else if (wr_fire) begin
			w_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid_reg <= 1'b0;
			bhit_reg   <= 1'b0;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			bhit_reg   <= wr_hit;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			link2_irq_enable_reg      <= `DLH_RESET_BYTE;
			lapd2_oversize_enable_reg <= `DLH_RESET_BYTE;
			link3_irq_enable_reg      <= `DLH_RESET_BYTE;
		end else begin
			if (wr_link2_en) begin
				link2_irq_enable_reg <= w_byte_reg & `DLH_LINK2_EN_MASK;
			end
			if (wr_ovr_en) begin
				lapd2_oversize_enable_reg <= w_byte_reg & `DLH_OVR_EN_MASK;
			end
			if (wr_link3_en) begin
				link3_irq_enable_reg <= w_byte_reg & `DLH_LINK3_EN_MASK;
			end
		end
	end

	// ********************
	// Interrupt request
	// ********************
	logic checksum_irq;
	logic abort_seq_irq;
	logic idle_flag_irq;
	logic lapd2_oversize_irq;
	logic link3_irq;

	assign checksum_irq       = fl_checksum.flag & link2_irq_enable_reg[`DLH_BIT_CHECKSUM];
	assign abort_seq_irq      = fl_abort.flag & link2_irq_enable_reg[`DLH_BIT_ABORT];
	assign idle_flag_irq      = fl_idle.flag & link2_irq_enable_reg[`DLH_BIT_IDLE];
	assign lapd2_oversize_irq = fl_oversize.flag & lapd2_oversize_enable_reg[`DLH_BIT_OVERSIZE];
	assign link3_irq = |(link3_status_byte & link3_irq_enable_reg);

	assign irq = checksum_irq | abort_seq_irq | idle_flag_irq | lapd2_oversize_irq | link3_irq;
endmodule : dlh_link_irq
`default_nettype wire

//--- dlh_link_irq_properties.sv
// Concurrent checks on the data-link interrupt status block ports.
`timescale 1ns/10ps
`default_nettype none
`include "dlh_cfg.svh"
module dlh_link_irq_checker (
	// Clock and reset.
	input wire logic               core_clk,
	input wire logic               rst_n,
	// Register bus.
	input wire logic               s_axi_awready,
	input wire logic               s_axi_wready,
	input wire logic [1:0]         s_axi_bresp,
	input wire logic               s_axi_bvalid,
	input wire logic               s_axi_bready,
	input wire logic               s_axi_arvalid,
	input wire logic               s_axi_arready,
	input wire dlh_pkg::dlh_word_t s_axi_rdata,
	input wire logic [1:0]         s_axi_rresp,
	input wire logic               s_axi_rvalid,
	input wire logic               s_axi_rready,
	// Events and interrupt.
	input wire logic               rx2_checksum_error,
	input wire logic               rx2_abort_seq,
	input wire logic               rx2_idle_flag,
	input wire logic               lapd2_oversize_event,
	input wire logic               tx3_begin,
	input wire logic               rx3_begin,
	input wire logic               tx3_done,
	input wire logic               irq
);
	import dlh_pkg::*;
	wire logic any_event;
	assign any_event = rx2_checksum_error | rx2_abort_seq | rx2_idle_flag | lapd2_oversize_event
		| tx3_begin | rx3_begin | tx3_done;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence r_answer;
		s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000;
	endsequence
	read_answer_a: assert property (ar_taken |=> r_answer) else $error("Read answer late.");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("Read data not held.");
	read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("Read accepted while busy.");
	read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("Read not retired.");
	write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("Write accepted while busy.");
	write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("Write response not held.");
	error_zero_a: assert property (s_axi_rvalid && s_axi_rresp == `DLH_RESP_SLVERR |-> s_axi_rdata == 32'h00000000)
		else $error("Error read carries data.");
	irq_rise_a: assert property ($rose(irq) |-> $rose(s_axi_bvalid) || $past(any_event))
		else $error("Interrupt rose without cause.");
	irq_fall_a: assert property ($fell(irq) |-> $rose(s_axi_bvalid) || $past(s_axi_arvalid && s_axi_arready))
		else $error("Interrupt fell without cause.");
endmodule : dlh_link_irq_checker
bind dlh_link_irq dlh_link_irq_checker u_dlh_link_irq_checker (.*);
`default_nettype wire

//--- dlh_link_irq_bench.sv
// Self-checking bench for the data-link interrupt status block.
`timescale 1ns/10ps
`default_nettype none
`include "dlh_cfg.svh"
module dlh_link_irq_bench;
	import dlh_pkg::*;
	logic [13:0] adr[5] = '{{`DLH_IDX_LINK2_IRQ_ENABLE, 2'b00}, {`DLH_IDX_LAPD2_OVR_STATUS, 2'b00},
		{`DLH_IDX_LAPD2_OVR_ENABLE, 2'b00}, {`DLH_IDX_LINK3_STATUS, 2'b00}, {`DLH_IDX_LINK3_ENABLE, 2'b00}};
	logic core_clk = 1'b0, rst_n = 1'b0, rx3_message_kind = 1'b0, k = 1'b0;
	logic [13:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = '0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	dlh_word_t s_axi_rdata;
	logic [7:0] ev = '0, en, set;
	logic [9:0] rq[$], exp_r;
	logic [1:0] bq[$], exp_b;
	int fail_count = 0, checked = 0, cycles = 0, seed = 33;
	wire logic rx2_idle_flag = ev[0], rx2_abort_seq = ev[1], rx2_checksum_error = ev[2];
	wire logic lapd2_oversize_event = ev[3], tx3_done = ev[4], rx3_begin = ev[5], tx3_begin = ev[6];
	dlh_link_irq u_dlh_link_irq (.*);
	initial begin
		forever #50 core_clk = ~core_clk;
	end
	task automatic note_err(input string m);
		$display("[ERR] %0t %s", $time, m);
		fail_count++;
	endtask : note_err
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			note_err("timeout");
			end_of_test();
		end
		if (s_axi_rvalid && s_axi_rready) begin
			exp_r = rq.pop_front();
			checked++;
			if ({s_axi_rresp, s_axi_rdata} !== {exp_r[9:8], 24'h000000, exp_r[7:0]}) note_err("read mismatch");
		end
		if (s_axi_bvalid && s_axi_bready) begin
			exp_b = bq.pop_front();
			checked++;
			if (s_axi_bresp !== exp_b) note_err("write response mismatch");
		end
	end
	task automatic wr(input logic [13:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] r);
		bq.push_back(r);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask : wr
	task automatic rd(input logic [13:0] a, input logic [7:0] d, input logic [1:0] r, input logic [7:0] e);
		rq.push_back({r, d});
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		ev <= e;
		forever begin
			@(posedge core_clk);
			ev <= 8'h00;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask : rd
	task automatic pulse(input logic [7:0] e);
		@(posedge core_clk);
		ev <= e;
		@(posedge core_clk);
		ev <= 8'h00;
	endtask : pulse
	task automatic chk_irq(input logic e);
		@(negedge core_clk);
		checked++;
		if (irq !== e) note_err("irq level mismatch");
	endtask : chk_irq
	initial begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		foreach (adr[i]) rd(adr[i], 8'h00, `DLH_RESP_OKAY, 8'h00);
		chk_irq(1'b0);
		$display("reset values done");
		for (int b = 0; b < 3; b++) begin
			wr(adr[0], 8'h01 << b, 4'h1, `DLH_RESP_OKAY);
			chk_irq(1'b0);
			pulse(8'h01 << b);
			chk_irq(1'b1);
			wr(adr[0], 8'h00, 4'h1, `DLH_RESP_OKAY);
			chk_irq(1'b0);
		end
		wr(adr[0], 8'hFF, 4'h0, `DLH_RESP_OKAY);
		rd(adr[0], 8'h00, `DLH_RESP_OKAY, 8'h00);
		wr(adr[0], 8'hFF, 4'h1, `DLH_RESP_OKAY);
		rd(adr[0], 8'h07, `DLH_RESP_OKAY, 8'h00);
		wr(adr[0], 8'h00, 4'h1, `DLH_RESP_OKAY);
		$display("link 2 enables done");
		pulse(8'h08);
		chk_irq(1'b0);
		rd(adr[1], 8'h01, `DLH_RESP_OKAY, 8'h00);
		rd(adr[1], 8'h00, `DLH_RESP_OKAY, 8'h00);
		wr(adr[2], 8'h01, 4'h1, `DLH_RESP_OKAY);
		rd(adr[2], 8'h01, `DLH_RESP_OKAY, 8'h00);
		pulse(8'h08);
		chk_irq(1'b1);
		wr(adr[1], 8'h00, 4'h1, `DLH_RESP_OKAY);
		chk_irq(1'b1);
		rd(adr[1], 8'h01, `DLH_RESP_OKAY, 8'h00);
		chk_irq(1'b0);
		wr(adr[2], 8'h00, 4'h1, `DLH_RESP_OKAY);
		$display("oversize done");
		for (int i = 0; i < 8; i++) begin
			en = 8'($random(seed));
			set = 8'($random(seed)) & 8'h70;
			k = 1'($random(seed));
			@(posedge core_clk);
			rx3_message_kind <= k;
			wr(adr[4], en, 4'h1, `DLH_RESP_OKAY);
			rd(adr[4], en & 8'h70, `DLH_RESP_OKAY, 8'h00);
			pulse(set);
			chk_irq(|(set & en & 8'h70));
			rd(adr[3], set | {k, 7'h00}, `DLH_RESP_OKAY, 8'h00);
			rd(adr[3], {k, 7'h00}, `DLH_RESP_OKAY, 8'h00);
		end
		rd(adr[3], {k, 7'h00}, `DLH_RESP_OKAY, 8'h40);
		rd(adr[3], {k, 7'h40}, `DLH_RESP_OKAY, 8'h00);
		wr(adr[3], 8'hFF, 4'h1, `DLH_RESP_OKAY);
		rd(adr[3], {k, 7'h00}, `DLH_RESP_OKAY, 8'h00);
		pulse(8'h40);
		rd(adr[3], {k, 7'h40}, `DLH_RESP_OKAY, 8'h00);
		pulse(8'h10);
		rd(adr[3], {k, 7'h10}, `DLH_RESP_OKAY, 8'h00);
		$display("link 3 status done");
		rd(14'h0000, 8'h00, `DLH_RESP_SLVERR, 8'h00);
		wr(14'h0000, 8'hFF, 4'h1, `DLH_RESP_SLVERR);
		$display("unmapped access done");
		repeat (4) @(posedge core_clk);
		end_of_test();
	end
endmodule : dlh_link_irq_bench
`default_nettype wire
